/* dsl_defs.vh */
`ifndef DSL_DEFS_VH
`define DSL_DEFS_VH

// Frame layout
`define DSL_FRAME_BITS      24
`define DSL_CNT_W           5
`define DSL_CODE_W          16
`define DSL_CODE_MSB        15
`define DSL_MODE_HI_POS     17
`define DSL_MODE_LO_POS     16
`define DSL_DONT_CARE_BITS  6

// Power mode encodings
`define DSL_MODE_NORMAL     2'h0
`define DSL_MODE_1K         2'h1
`define DSL_MODE_100K       2'h2
`define DSL_MODE_HIZ        2'h3

// Reset values and last bit count
`define DSL_CODE_RST        16'h0000
`define DSL_MODE_RST        2'h0
`define DSL_CNT_RST         5'h00
`define DSL_CNT_LAST        5'h17
`define DSL_FRAME_RST       24'h000000

`endif

/* dsl_serial_dac_ctrl.v */
`timescale 1ns/1ps
`default_nettype none
`include "dsl_defs.vh"

module dsl_serial_dac_ctrl #(
    parameter FRAME_BITS = `DSL_FRAME_BITS,
    parameter CODE_W     = `DSL_CODE_W
) (
    input  wire              clk_sys_i,
    input  wire              rst_i,
    input  wire              frame_sel_n_i,
    input  wire              shift_clk_i,
    input  wire              serial_data_i,
    input  wire              code_ready_i,
    output reg  [CODE_W-1:0] dac_code_o,
    output reg  [1:0]        power_mode_o,
    output reg               code_valid_o,
    output reg               amp_enable_o,
    output reg               term_1k_o,
    output reg               term_100k_o,
    output reg               analog_on_o,
    output reg               frame_done_o
);

    // Timing through the block, in system clock cycles
    // Each link pin passes two flip-flops before any logic reads it.
    // One more stage of history turns the levels into edge strobes.
    // A shift-clock fall is therefore seen about three cycles late.
    // Data is taken from the same synchroniser depth as the clock,
    // so a bit that is steady around the fall is captured intact.
    // The shift clock must stay high and low for two cycles or more;
    // shorter phases can slip between samples and lose an edge.
    //
    // Frame handling
    // A select fall starts a fresh frame and clears the counter.
    // A select rise clears the counter and the partial frame, so a
    // frame cut short leaves both the code and the mode untouched.
    // The 24th fall marks the frame full; later falls are ignored
    // until select rises and falls again.
    //
    // Buffering
    // A full frame is pushed into a two-entry buffer one cycle after
    // the last fall, provided an entry is free. When both entries
    // are taken the new frame is dropped and no done pulse is sent.
    // The head is applied in the cycle in which code_ready_i is high.
    //
    // Applied state
    // The mode field and the code are applied together from one
    // buffer entry. A power-down frame still carries a code, which
    // is applied; the code register is never cleared by a mode.
    // All outputs are registered; code, mode and the decoded lines trail the applied state by one cycle.
    //
    // Limits
    // There is no timer: wake-up time after leaving power-down is the
    // host's to respect. Reset is synchronous and clears the code, mode and buffer; amp_enable_o and analog_on_o reset high.

    // Two-stage synchronisers for the three link pins
    reg                  sel_s1;
    reg                  sel_s2;
    reg                  clk_s1;
    reg                  clk_s2;
    reg                  dat_s1;
    reg                  dat_s2;
    // Edge detection history, read only from second stages
    reg                  sel_d;
    reg                  clk_d;
    // Shift state
    reg [FRAME_BITS-1:0] serial_input_frame;
    reg [`DSL_CNT_W-1:0] bit_cnt;
    reg                  frame_full;
    // Two-entry buffer of executed frames (mode + code)
    reg [CODE_W+1:0]     buf_data [0:1];
    reg [1:0]            buf_vld;
    reg                  buf_wr;
    reg                  buf_rd;
    // Applied state
    reg [1:0]            power_mode;
    reg [CODE_W-1:0]     code;
    // Decoded mode, registered into the outputs
    reg                  next_amp_enable;
    reg                  next_term_1k;
    reg                  next_term_100k;
    reg                  next_analog_on;

    wire                 sel_fall;
    wire                 sel_rise;
    wire                 sclk_fall;
    wire [FRAME_BITS-1:0] next_frame;
    wire                 last_edge;
    wire                 buf_in_ready;
    wire                 buf_out_valid;
    wire [CODE_W+1:0]    buf_out_data;

    // Synchronise the link pins into the system clock
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            sel_s1 <= 1'b1;
            sel_s2 <= 1'b1;
            clk_s1 <= 1'b0;
            clk_s2 <= 1'b0;
            dat_s1 <= 1'b0;
            dat_s2 <= 1'b0;
            sel_d  <= 1'b1;
            clk_d  <= 1'b0;
        end else begin
            sel_s1 <= frame_sel_n_i;
            sel_s2 <= sel_s1;
            clk_s1 <= shift_clk_i;
            clk_s2 <= clk_s1;
            dat_s1 <= serial_data_i;
            dat_s2 <= dat_s1;
            sel_d  <= sel_s2;
            clk_d  <= clk_s2;
        end
    end

    // Edge finding on synchronised levels
    // Both select edges are found so that a new frame and an
    // aborted frame each start from a clean counter.
    assign sel_fall  = sel_d & ~sel_s2;
    assign sel_rise  = ~sel_d & sel_s2;
    assign sclk_fall = clk_d & ~clk_s2 & ~sel_s2;
    // MSB arrives first, so shift toward the top
    assign next_frame = {serial_input_frame[FRAME_BITS-2:0], dat_s2};
    assign last_edge  = sclk_fall & ~frame_full & (bit_cnt == `DSL_CNT_LAST);

    // Input shift register and edge counter
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            serial_input_frame <= `DSL_FRAME_RST;
            bit_cnt            <= `DSL_CNT_RST;
            frame_full         <= 1'b0;
            buf_wr             <= 1'b0;
        end else begin
            buf_wr <= 1'b0;
            if (sel_rise || sel_fall) begin
                // Early rise clears the frame with no effect
                serial_input_frame <= `DSL_FRAME_RST;
                bit_cnt            <= `DSL_CNT_RST;
                frame_full         <= 1'b0;
            end else if (sclk_fall && !frame_full) begin
                serial_input_frame <= next_frame;
                bit_cnt            <= bit_cnt + 5'h01;
                if (last_edge) begin
                    frame_full <= 1'b1;
                    buf_wr     <= buf_in_ready;
                end
            end
        end
    end

    // Two-entry buffer: head is entry 0
    assign buf_in_ready  = ~buf_vld[1];
    assign buf_out_valid = buf_vld[0];
    assign buf_out_data  = buf_data[0];

    always @* begin
        buf_rd = buf_out_valid & code_ready_i;
    end

    // Buffer write takes the mode field and the code, top bits skipped
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            buf_vld     <= 2'h0;
            buf_data[0] <= {(CODE_W+2){1'b0}};
            buf_data[1] <= {(CODE_W+2){1'b0}};
        end else begin
            case ({buf_wr, buf_rd})
                2'b10: begin
                    if (buf_vld[0]) begin
                        buf_data[1] <= serial_input_frame[CODE_W+1:0];
                        buf_vld[1]  <= 1'b1;
                    end else begin
                        buf_data[0] <= serial_input_frame[CODE_W+1:0];
                        buf_vld[0]  <= 1'b1;
                    end
                end
                2'b01: begin
                    buf_data[0] <= buf_data[1];
                    buf_vld     <= {1'b0, buf_vld[1]};
                end
                2'b11: begin
                    if (buf_vld[1]) begin
                        buf_data[0] <= buf_data[1];
                        buf_data[1] <= serial_input_frame[CODE_W+1:0];
                    end else begin
                        buf_data[0] <= serial_input_frame[CODE_W+1:0];
                    end
                end
                default: begin
                    buf_vld <= buf_vld;
                end
            endcase
        end
    end

    // Apply buffered frames; code kept across power-down
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            code       <= `DSL_CODE_RST;
            power_mode <= `DSL_MODE_RST;
        end else if (buf_rd) begin
            power_mode <= buf_out_data[CODE_W+1:CODE_W];
            code       <= buf_out_data[CODE_W-1:0];
        end
    end

    // Mode decode: normal drives the amplifier, 1k and 100k pick a load, high-Z picks none
    always @* begin
        next_amp_enable = 1'b0;
        next_term_1k    = 1'b0;
        next_term_100k  = 1'b0;
        next_analog_on  = 1'b0;
        case (power_mode)
            `DSL_MODE_NORMAL: begin
                next_amp_enable = 1'b1;
                next_analog_on  = 1'b1;
            end
            `DSL_MODE_1K: begin
                next_term_1k = 1'b1;
            end
            `DSL_MODE_100K: begin
                next_term_100k = 1'b1;
            end
            `DSL_MODE_HIZ: begin
                // Output left open, no load selected
                next_term_1k = 1'b0;
            end
            default: begin
                next_amp_enable = 1'b0;
            end
        endcase
    end

    // Registered outputs decoded from the applied state
    // The decode is registered so no output glitches on a mode change
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            dac_code_o   <= `DSL_CODE_RST;
            power_mode_o <= `DSL_MODE_RST;
            code_valid_o <= 1'b0;
            amp_enable_o <= 1'b1;
            term_1k_o    <= 1'b0;
            term_100k_o  <= 1'b0;
            analog_on_o  <= 1'b1;
            frame_done_o <= 1'b0;
        end else begin
            dac_code_o   <= code;
            power_mode_o <= power_mode;
            code_valid_o <= buf_out_valid;
            frame_done_o <= buf_wr;
            amp_enable_o <= next_amp_enable;
            analog_on_o  <= next_analog_on;
            term_1k_o    <= next_term_1k;
            term_100k_o  <= next_term_100k;
        end
    end

endmodule
`default_nettype wire

/* dsl_ctrl_checker.sv */
`timescale 1ns/1ps
`default_nettype none
// Port-level checks of the serial control block
module dsl_ctrl_checker #(
    parameter FRAME_BITS = 24,
    parameter CODE_W     = 16
) (
    input wire logic              clk_sys_i,
    input wire logic              rst_i,
    input wire logic              frame_sel_n_i,
    input wire logic              shift_clk_i,
    input wire logic              serial_data_i,
    input wire logic              code_ready_i,
    input wire logic [CODE_W-1:0] dac_code_o,
    input wire logic [1:0]        power_mode_o,
    input wire logic              code_valid_o,
    input wire logic              amp_enable_o,
    input wire logic              term_1k_o,
    input wire logic              term_100k_o,
    input wire logic              analog_on_o,
    input wire logic              frame_done_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    // Steps of a frame as seen at the ports
    sequence s_idle; frame_sel_n_i [*8]; endsequence
    sequence s_done; frame_done_o; endsequence
    done_pulse_a: assert property (s_done |=> !frame_done_o)
        else $error("frame done longer than one cycle");
    idle_quiet_a: assert property (s_idle |=> !frame_done_o)
        else $error("frame done while deselected");
    done_valid_a: assert property (s_done |=> code_valid_o)
        else $error("frame done without buffered frame");
    state_hold_a: assert property ($changed({power_mode_o, dac_code_o})
        |-> $past(code_valid_o && code_ready_i)) else $error("state changed without a frame");
    amp_mode_a: assert property (amp_enable_o == (power_mode_o == 2'h0)
        && analog_on_o == amp_enable_o) else $error("amplifier state wrong for mode");
    term_1k_a: assert property (term_1k_o == (power_mode_o == 2'h1))
        else $error("1k termination wrong for mode");
    term_100k_a: assert property (term_100k_o == (power_mode_o == 2'h2))
        else $error("100k termination wrong for mode");
    reset_zero_a: assert property ($fell(rst_i) |-> dac_code_o == '0
        && power_mode_o == 2'h0 && !code_valid_o) else $error("state not cleared by reset");
endmodule
`default_nettype wire

/* dsl_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Host end of the link; shift clock idles high outside frames
module dsl_host_model (
    output var logic frame_sel_n,
    output var logic shift_clk,
    output var logic serial_data
);
    initial begin
        frame_sel_n = 1'b1;
        shift_clk = 1'b1;
        serial_data = 1'b0;
    end
    // Sends n bits MSB first; bits past the 24th are random
    task automatic send(input logic [23:0] w, input int n);
        int i;
        frame_sel_n = 1'b0;
        for (i = 0; i < n; i++) begin
            serial_data = (i < 24) ? w[23 - i] : 1'($urandom);
            #100 shift_clk = 1'b0;
            #100 shift_clk = 1'b1;
        end
        frame_sel_n = 1'b1;
        serial_data = ~serial_data;
        #200;
    endtask
endmodule
`default_nettype wire

/* tb_dsl_serial_dac_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_dsl_serial_dac_ctrl;
    logic        clk_sys_i, rst_i, code_ready_i;
    wire         frame_sel_n_i, shift_clk_i, serial_data_i;
    logic [15:0] dac_code_o, last, code;
    logic [1:0]  power_mode_o, last_mode, mode;
    logic        code_valid_o, amp_enable_o, term_1k_o, term_100k_o, analog_on_o, frame_done_o;
    int          num_errors = 0;
    int          compares = 0;
    int          m;
    dsl_host_model i_host (.frame_sel_n(frame_sel_n_i), .shift_clk(shift_clk_i),
        .serial_data(serial_data_i));
    dsl_serial_dac_ctrl i_dsl_serial_dac_ctrl (.*);
    initial begin
        clk_sys_i = 1'b0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end
    // Expected amplifier, terminations and analog power for a mode
    function automatic logic [3:0] dec(input logic [1:0] md);
        return {md == 2'h0, md == 2'h1, md == 2'h2, md == 2'h0};
    endfunction
    task automatic chk(input logic [23:0] g, input logic [23:0] e);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic chk_out;
        chk({power_mode_o, dac_code_o}, {last_mode, last});
        chk({amp_enable_o, term_1k_o, term_100k_o, analog_on_o}, dec(last_mode));
    endtask
    task automatic end_of_test;
        if (num_errors == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // One frame with random leading bits; a whole frame becomes the new state
    task automatic put(input logic [1:0] md, input logic [15:0] cd, input int n);
        i_host.send({6'($urandom), md, cd}, n);
        if (n >= 24) {last_mode, last} = {md, cd};
        @(negedge clk_sys_i);
    endtask
    initial begin
        void'($urandom(32'h4826));
        rst_i = 1'b1;
        code_ready_i = 1'b1;
        {last_mode, last} = 18'h00000;
        repeat (6) @(negedge clk_sys_i);
        rst_i = 1'b0;
        repeat (3) @(negedge clk_sys_i);
        chk_out;
        // Each mode twice with random codes, then full scale, a short frame and a long one
        for (m = 0; m < 8; m++) begin
            put(2'(m), 16'($urandom), 24);
            chk_out;
        end
        put(2'h0, 16'hFFFF, 24);
        chk_out;
        put(2'h1, 16'h1234, 23);
        chk_out;
        put(2'h2, 16'hA5A5, 28);
        chk_out;
        // Stall: two frames fill the buffer, the third is dropped
        {mode, code} = {last_mode, last};
        code_ready_i = 1'b0;
        put(2'h1, 16'h1111, 24);
        put(2'h3, 16'h2222, 24);
        i_host.send({6'h00, 2'h1, 16'h3333}, 24);
        @(negedge clk_sys_i);
        chk(code_valid_o, 24'h000001);
        chk({power_mode_o, dac_code_o}, {mode, code});
        code_ready_i = 1'b1;
        repeat (4) @(negedge clk_sys_i);
        chk_out;
        // Reset in mid-run clears the code again
        rst_i = 1'b1;
        repeat (2) @(negedge clk_sys_i);
        rst_i = 1'b0;
        {last_mode, last} = 18'h00000;
        repeat (3) @(negedge clk_sys_i);
        chk_out;
        end_of_test;
    end
    initial begin
        #200000;
        num_errors++;
        end_of_test;
    end
endmodule
bind dsl_serial_dac_ctrl dsl_ctrl_checker #(.FRAME_BITS(FRAME_BITS), .CODE_W(CODE_W)) i_chk (.*);
`default_nettype wire
